/* File: src/eba_pkg.sv */
// Shared constants for the byte-wide nonvolatile data store access block
package eba_pkg;

  // Array geometry
  localparam int          NV_BYTES       = 1024;
  localparam int          NV_ADDR_W      = 10;
  localparam int          NV_DATA_W      = 8;

  // I/O register select width and register offsets
  localparam int          IO_ADDR_W      = 6;
  localparam logic [5:0]  OFF_ADDR_LOW   = 6'h10;
  localparam logic [5:0]  OFF_ADDR_HIGH  = 6'h11;
  localparam logic [5:0]  OFF_DATA       = 6'h12;
  localparam logic [5:0]  OFF_CONTROL    = 6'h13;

  // Control register field positions
  localparam int          CTL_READ_BIT   = 0;
  localparam int          CTL_STROBE_BIT = 1;
  localparam int          CTL_ARM_BIT    = 2;

  // Values after reset
  localparam logic [9:0]  ADDR_RESET     = 10'h000;
  localparam logic [7:0]  DATA_RESET     = 8'h00;

  // Cycle counts on the CPU clock
  localparam logic [2:0]  ARM_CYCLES     = 3'h4;
  localparam logic [2:0]  READ_STALL     = 3'h4;
  localparam logic [2:0]  WRITE_STALL    = 3'h2;

  // Write duration in calibrated oscillator cycles
  localparam int          WRITE_OSC_CYCLES = 8448;
  localparam int          OSC_CNT_W        = 14;

  // Write sequencer states, Gray coded along idle, busy, commit
  typedef enum logic [1:0] {
    EBA_WR_IDLE   = 2'b00,
    EBA_WR_BUSY   = 2'b01,
    EBA_WR_COMMIT = 2'b11
  } eba_wr_e;

endpackage : eba_pkg

/* File: src/eba_array.sv */
// Byte-addressed nonvolatile storage array, one write port and one read port
`timescale 1ns/1ps

module eba_array (
  input  wire logic       clk_i,    // CPU clock
  input  wire logic       ce_i,     // Clock enable
  input  wire logic       we_i,     // Commit strobe
  input  wire logic [9:0] waddr_i,  // Commit address
  input  wire logic [7:0] wdata_i,  // Commit byte
  input  wire logic [9:0] raddr_i,  // Read address
  output logic      [7:0] rdata_o   // Read byte, combinational
);

  // Storage has no reset: its contents are meant to outlive one
  logic [7:0] mem_q [eba_pkg::NV_BYTES];

  // Each byte is written on its own
  always_ff @(posedge clk_i)
  begin
    if (ce_i && we_i)
    begin
      mem_q[waddr_i] <= wdata_i;
    end
  end

  // Read is asynchronous so the result lands within the trigger cycle
  assign rdata_o = mem_q[raddr_i];

endmodule : eba_array

/* File: src/eba_access.sv */
// CPU-side access logic for the byte-wide nonvolatile data store
//
// Behaviour
// RULE_01: A separate 1024-byte store, each byte read or written alone.
// RULE_02: Address bits 15..10 are reserved and always read as zero.
// RULE_03: Address bits 9..0 index bytes 0 through 1023 linearly.
// RULE_04: Address needs no meaningful reset; software loads it before use.
// RULE_05: A read stalls the CPU for four clock cycles.
// RULE_06: A write start stalls the CPU for two clock cycles.
// RULE_07: A write stores the data register byte at the addressed location.
// RULE_08: A read loads the data register from the addressed location.
// RULE_09: Writes are self-timed; a pollable bit shows completion.
// RULE_10: A write starts only after the guarded arm-then-strobe sequence.
// RULE_11: Address, data and control registers are CPU readable and writable.
// RULE_12: Arm bit self-clears four cycles after set; strobe needs arm set.
// RULE_13: Strobe clears at write end; reads and address writes ignored meanwhile.
// RULE_14: Read strobe result is in the data register immediately.
// RULE_15: A write lasts 8448 calibrated oscillator cycles.
// RULE_16: Array changes only at timed write completion after a valid sequence.
// RULE_17: Write-in-progress bit stays set from start until completion.
`timescale 1ns/1ps

module eba_access #(
  parameter int WRITE_OSC_CYCLES = eba_pkg::WRITE_OSC_CYCLES  // Oscillator cycles per write
) (
  input  wire logic       clk_i,      // CPU clock, 20 MHz
  input  wire logic       sys_rst_i,  // Asynchronous reset, active high
  input  wire logic       ce_i,       // Clock enable, freezes all state when low
  input  wire logic [5:0] io_addr_i,  // I/O register select
  input  wire logic       io_we_i,    // I/O write strobe
  input  wire logic       io_re_i,    // I/O read strobe
  input  wire logic [7:0] io_wdata_i, // I/O write data
  input  wire logic       osc_i,      // Calibrated oscillator, asynchronous
  output logic      [7:0] io_rdata_o, // I/O read data, registered
  output logic            cpu_stall_o,// CPU halt request
  output logic            wr_busy_o   // Write in progress
);

  localparam logic [13:0] OSC_LAST = 14'(WRITE_OSC_CYCLES - 1);

  // Register decode shared by the read and write paths
  function automatic logic reg_hit(input logic [5:0] addr, input logic [5:0] off);
    reg_hit = (addr == off);
  endfunction : reg_hit

  logic [9:0]       nv_address_q;
  logic [7:0]       nv_data_q;
  logic             master_write_arm_q;
  logic [2:0]       arm_cnt_q;
  logic             write_strobe_q;
  logic [2:0]       stall_cnt_q;
  logic             stall_q;
  logic [9:0]       wr_addr_q;
  logic [7:0]       wr_data_q;
  logic [13:0]      osc_cnt_q;
  logic             osc_s1_q;
  logic             osc_s2_q;
  logic             osc_s3_q;
  logic [7:0]       rdata_q;
  logic             busy_q;
  eba_pkg::eba_wr_e wr_state_q;
  eba_pkg::eba_wr_e wr_state_d;

  logic       ctl_wr;
  logic       arm_load;
  logic       wr_start;
  logic       rd_start;
  logic       osc_rise;
  logic       mem_we;
  logic [7:0] mem_rdata;

  // Decode of CPU requests; a request while the CPU is halted is not expected
  assign ctl_wr   = ce_i && io_we_i && reg_hit(io_addr_i, eba_pkg::OFF_CONTROL);
  assign arm_load = ctl_wr && io_wdata_i[eba_pkg::CTL_ARM_BIT]; // RULE_12
  assign wr_start = ctl_wr && io_wdata_i[eba_pkg::CTL_STROBE_BIT] && master_write_arm_q
                    && !write_strobe_q && !stall_q; // RULE_10 RULE_12
  assign rd_start = ctl_wr && io_wdata_i[eba_pkg::CTL_READ_BIT] && !write_strobe_q
                    && !wr_start && !stall_q; // RULE_13
  assign osc_rise = osc_s2_q && !osc_s3_q;
  assign mem_we   = ce_i && (wr_state_q == eba_pkg::EBA_WR_COMMIT); // RULE_16

  // Storage array, read at the live address so a read needs no extra cycle
  eba_array u_array (
    .clk_i   (clk_i),
    .ce_i    (ce_i),
    .we_i    (mem_we),
    .waddr_i (wr_addr_q),
    .wdata_i (wr_data_q),
    .raddr_i (nv_address_q),
    .rdata_o (mem_rdata)
  ); // RULE_01

  // Address register, 10 bits; the upper byte keeps only two bits
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      nv_address_q <= eba_pkg::ADDR_RESET; // RULE_04
    end
    else if (ce_i && io_we_i && !write_strobe_q) // RULE_13
    begin
      if (reg_hit(io_addr_i, eba_pkg::OFF_ADDR_LOW))
      begin
        nv_address_q[7:0] <= io_wdata_i; // RULE_03
      end
      else if (reg_hit(io_addr_i, eba_pkg::OFF_ADDR_HIGH))
      begin
        nv_address_q[9:8] <= io_wdata_i[1:0]; // RULE_02
      end
    end
  end

  // Data register: CPU writes it, a read strobe overwrites it with the fetched byte
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      nv_data_q <= eba_pkg::DATA_RESET;
    end
    else if (rd_start)
    begin
      nv_data_q <= mem_rdata; // RULE_08 RULE_14
    end
    else if (ce_i && io_we_i && reg_hit(io_addr_i, eba_pkg::OFF_DATA))
    begin
      nv_data_q <= io_wdata_i; // RULE_11
    end
  end

  // Arm bit with its own timeout; a fresh write reloads the window
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      master_write_arm_q <= 1'b0;
      arm_cnt_q          <= 3'h0;
    end
    else if (arm_load)
    begin
      master_write_arm_q <= 1'b1;
      arm_cnt_q          <= eba_pkg::ARM_CYCLES - 3'h1; // RULE_12
    end
    else if (ce_i && master_write_arm_q)
    begin
      if (arm_cnt_q == 3'h0)
      begin
        master_write_arm_q <= 1'b0; // RULE_12
      end
      else
      begin
        arm_cnt_q <= arm_cnt_q - 3'h1;
      end
    end
  end

  // CPU halt counter, shared by reads and write starts
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      stall_cnt_q <= 3'h0;
      stall_q     <= 1'b0;
    end
    else if (rd_start)
    begin
      stall_cnt_q <= eba_pkg::READ_STALL; // RULE_05
      stall_q     <= 1'b1;
    end
    else if (wr_start)
    begin
      stall_cnt_q <= eba_pkg::WRITE_STALL; // RULE_06
      stall_q     <= 1'b1;
    end
    else if (ce_i && stall_cnt_q != 3'h0)
    begin
      stall_cnt_q <= stall_cnt_q - 3'h1;
      stall_q     <= (stall_cnt_q > 3'h1);
    end
  end

  // Oscillator synchroniser; edge detect looks only past the second stage
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      osc_s1_q <= 1'b0;
      osc_s2_q <= 1'b0;
      osc_s3_q <= 1'b0;
    end
    else if (ce_i)
    begin
      osc_s1_q <= osc_i;
      osc_s2_q <= osc_s1_q;
      osc_s3_q <= osc_s2_q;
    end
  end

  // Write sequencer next state
  always_comb
  begin
    wr_state_d = wr_state_q;
    case (wr_state_q)
      eba_pkg::EBA_WR_IDLE:
      begin
        if (wr_start)
        begin
          wr_state_d = eba_pkg::EBA_WR_BUSY;
        end
      end
      eba_pkg::EBA_WR_BUSY:
      begin
        if (osc_rise && osc_cnt_q == OSC_LAST) // RULE_15
        begin
          wr_state_d = eba_pkg::EBA_WR_COMMIT;
        end
      end
      eba_pkg::EBA_WR_COMMIT:
      begin
        wr_state_d = eba_pkg::EBA_WR_IDLE;
      end
      default:
      begin
        wr_state_d = eba_pkg::EBA_WR_IDLE;
      end
    endcase
  end

  // Write sequencer state, oscillator count and the latched write operands
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      wr_state_q <= eba_pkg::EBA_WR_IDLE;
      osc_cnt_q  <= 14'h0000;
      wr_addr_q  <= eba_pkg::ADDR_RESET;
      wr_data_q  <= eba_pkg::DATA_RESET;
    end
    else if (ce_i)
    begin
      wr_state_q <= wr_state_d;
      if (wr_start)
      begin
        // Data is latched so a later data register write cannot corrupt the byte
        wr_addr_q <= nv_address_q;
        wr_data_q <= nv_data_q; // RULE_07
        osc_cnt_q <= 14'h0000;
      end
      else if (wr_state_q == eba_pkg::EBA_WR_BUSY && osc_rise)
      begin
        osc_cnt_q <= osc_cnt_q + 14'h0001; // RULE_15
      end
    end
  end

  // Write strobe bit doubles as the busy flag software polls
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      write_strobe_q <= 1'b0;
      busy_q         <= 1'b0;
    end
    else if (wr_start)
    begin
      write_strobe_q <= 1'b1; // RULE_17
      busy_q         <= 1'b1;
    end
    else if (mem_we)
    begin
      write_strobe_q <= 1'b0; // RULE_09 RULE_13
      busy_q         <= 1'b0;
    end
  end

  // Registered read port; reserved bits come back as zero
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      rdata_q <= 8'h00;
    end
    else if (ce_i && io_re_i)
    begin
      case (1'b1)
        reg_hit(io_addr_i, eba_pkg::OFF_ADDR_LOW):  rdata_q <= nv_address_q[7:0];
        reg_hit(io_addr_i, eba_pkg::OFF_ADDR_HIGH): rdata_q <= {6'h00, nv_address_q[9:8]};
        reg_hit(io_addr_i, eba_pkg::OFF_DATA):      rdata_q <= nv_data_q; // RULE_11
        reg_hit(io_addr_i, eba_pkg::OFF_CONTROL):
          rdata_q <= {5'h00, master_write_arm_q, write_strobe_q, 1'b0}; // RULE_09
        default:                                    rdata_q <= 8'h00;
      endcase
    end
  end

  assign io_rdata_o  = rdata_q;
  assign cpu_stall_o = stall_q;
  assign wr_busy_o   = busy_q;

  // Checks run on enabled edges only, since a low enable freezes everything
  default clocking cb @(posedge clk_i iff ce_i);
  endclocking
  default disable iff (sys_rst_i);

  arm_hold_a: assert property (arm_load |=> master_write_arm_q [*4]) // RULE_12
    else $error("arm bit dropped before four cycles");

  arm_clear_a: assert property (arm_load ##1 (!arm_load) [*4] |=> !master_write_arm_q) // RULE_12
    else $error("arm bit not cleared after four cycles");

  read_stall_a: assert property (rd_start |=> cpu_stall_o [*4] ##1 !cpu_stall_o) // RULE_05
    else $error("read stall is not four cycles");

  write_stall_a: assert property (wr_start |=> cpu_stall_o [*2] ##1 !cpu_stall_o) // RULE_06
    else $error("write stall is not two cycles");

  read_data_a: assert property (rd_start |=> nv_data_q == $past(mem_rdata)) // RULE_14
    else $error("read byte not loaded at once");

  guarded_start_a: assert property ($rose(write_strobe_q) |-> $past(master_write_arm_q)) // RULE_10
    else $error("write started without arm");

  addr_lock_a: assert property (write_strobe_q |=> $stable(nv_address_q)) // RULE_13
    else $error("address changed during write");

  busy_span_a: assert property (wr_start |=> write_strobe_q [*8]) // RULE_17
    else $error("busy bit dropped early");

  commit_end_a: assert property ($fell(write_strobe_q) |-> $past(mem_we)) // RULE_16
    else $error("busy cleared without commit");

  reserved_zero_a: assert property
    (io_re_i && reg_hit(io_addr_i, eba_pkg::OFF_ADDR_HIGH) |=> io_rdata_o[7:2] == 6'h00) // RULE_02
    else $error("reserved address bits read nonzero");

endmodule : eba_access

/* File: dv/eba_osc_model.sv */
// Free-running calibrated oscillator that times the nonvolatile writes
`timescale 1ns/1ps

module eba_osc_model #(
  parameter int HALF_NS = 85  // Half period, kept above one CPU clock period
) (
  output logic osc_o  // Oscillator output
);
  // Odd start offset keeps the phase unrelated to the CPU clock
  initial
  begin
    osc_o = 1'b0;
    #13;
    forever #(HALF_NS) osc_o = ~osc_o;
  end
endmodule : eba_osc_model

/* File: dv/eba_access_tb.sv */
// Self-checking bench for the nonvolatile byte store access block
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin num_errors++; \
  $display("wrong value %s expected %h seen %h", nm, ex, got); end end

module eba_access_tb;
  localparam int WOSC = 8;
  localparam logic [5:0] CTL = eba_pkg::OFF_CONTROL;
  logic        clk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic        ce_i = 1'b1;
  logic        osc_p = 1'b0;
  logic [1:0]  osc_pipe = 2'h0;
  logic [5:0]  io_addr_i = 6'h00;
  logic        io_we_i = 1'b0;
  logic        io_re_i = 1'b0;
  logic [7:0]  io_wdata_i = 8'h00;
  logic        osc;
  logic [7:0]  io_rdata_o;
  logic        cpu_stall_o;
  logic        wr_busy_o;
  int          num_errors = 0;
  int          checks_done = 0;
  int          osc_seen = 0;
  int unsigned seed = 7349;
  logic [7:0]  mem [1024];
  logic [7:0]  rd;
  logic [9:0]  adr;
  int          n;

  always #25 clk_i = ~clk_i;

  eba_osc_model #(.HALF_NS(85)) osc_u (.osc_o(osc));

  eba_access #(.WRITE_OSC_CYCLES(WOSC)) dut_u (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i), .io_addr_i(io_addr_i),
    .io_we_i(io_we_i), .io_re_i(io_re_i), .io_wdata_i(io_wdata_i), .osc_i(osc),
    .io_rdata_o(io_rdata_o), .cpu_stall_o(cpu_stall_o), .wr_busy_o(wr_busy_o)
  );

  // Oscillator rises as the block sees them: caught at one clock edge, counted two edges on,
  // so a rise just before the start or just after the last count is not miscounted
  always @(posedge clk_i)
  begin
    osc_p <= osc;
    osc_pipe <= {osc_pipe[0], osc && !osc_p};
    if (osc_pipe[1] && wr_busy_o === 1'b1) osc_seen++;
  end

  function automatic int unsigned xs(input int unsigned v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction : xs

  task automatic final_report;
    if (num_errors == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report

  // One idle cycle between accesses, so no strobe is driven twice in a step
  task automatic io_wr(input logic [5:0] a, input logic [7:0] d);
    @(negedge clk_i);
    io_addr_i = a;
    io_wdata_i = d;
    io_we_i = 1'b1;
    @(negedge clk_i);
    io_we_i = 1'b0;
  endtask : io_wr

  task automatic io_rd(input logic [5:0] a, output logic [7:0] d);
    @(negedge clk_i);
    io_addr_i = a;
    io_re_i = 1'b1;
    @(negedge clk_i);
    io_re_i = 1'b0;
    d = io_rdata_o;
  endtask : io_rd

  // Halt length, counted from the cycle after the launching edge
  task automatic stall_len(output int c);
    c = 0;
    while (cpu_stall_o === 1'b1 && c < 20)
    begin
      c++;
      @(negedge clk_i);
    end
  endtask : stall_len

  task automatic set_addr(input logic [9:0] a);
    io_wr(eba_pkg::OFF_ADDR_LOW, a[7:0]);
    io_wr(eba_pkg::OFF_ADDR_HIGH, {6'h00, a[9:8]});
  endtask : set_addr

  task automatic nv_read(input logic [9:0] a);
    set_addr(a);
    io_wr(CTL, 8'h01);
    stall_len(n);
    `CHK("read halt", 4, n)
    io_rd(eba_pkg::OFF_DATA, rd);
    `CHK("read byte", mem[a], rd)
  endtask : nv_read

  task automatic nv_write(input logic [9:0] a, input logic [7:0] d, input bit probe);
    set_addr(a);
    io_wr(eba_pkg::OFF_DATA, d);
    osc_seen = 0;
    io_wr(CTL, 8'h04);
    io_wr(CTL, 8'h02);
    stall_len(n);
    `CHK("write halt", 2, n)
    `CHK("busy", 1'b1, wr_busy_o)
    if (probe)
    begin
      // Address change and read strobe must both be ignored mid-write
      io_wr(eba_pkg::OFF_ADDR_LOW, ~a[7:0]);
      io_wr(CTL, 8'h01);
      `CHK("halt on busy read", 1'b0, cpu_stall_o)
      io_rd(eba_pkg::OFF_ADDR_LOW, rd);
      `CHK("address in write", a[7:0], rd)
      io_rd(eba_pkg::OFF_DATA, rd);
      `CHK("data in write", d, rd)
      io_rd(CTL, rd);
      `CHK("control in write", 8'h02, rd)
    end
    n = 0;
    while (wr_busy_o === 1'b1 && n < 500)
    begin
      n++;
      @(negedge clk_i);
    end
    if (n >= 500)
    begin
      num_errors++;
      final_report();
    end
    `CHK("osc edges", WOSC, osc_seen)
    io_rd(CTL, rd);
    `CHK("control idle", 8'h00, rd)
    mem[a] = d;
  endtask : nv_write

  initial
  begin
    repeat (4) @(negedge clk_i);
    sys_rst_i = 1'b0;
    io_rd(CTL, rd);
    `CHK("control reset", 8'h00, rd)
    io_rd(eba_pkg::OFF_DATA, rd);
    `CHK("data reset", eba_pkg::DATA_RESET, rd)
    io_rd(6'h00, rd);
    `CHK("unmapped", 8'h00, rd)
    // Register access with random values
    for (int i = 0; i < 4; i++)
    begin
      seed = xs(seed);
      io_wr(eba_pkg::OFF_ADDR_LOW, seed[7:0]);
      io_wr(eba_pkg::OFF_ADDR_HIGH, seed[15:8]);
      io_wr(eba_pkg::OFF_DATA, seed[23:16]);
      io_rd(eba_pkg::OFF_ADDR_LOW, rd);
      `CHK("address low", seed[7:0], rd)
      io_rd(eba_pkg::OFF_ADDR_HIGH, rd);
      `CHK("address high", {6'h00, seed[9:8]}, rd)
      io_rd(eba_pkg::OFF_DATA, rd);
      `CHK("data", seed[23:16], rd)
    end
    // Boundary and random locations, written then read back
    for (int i = 0; i < 4; i++)
    begin
      seed = xs(seed);
      adr = (i == 0) ? 10'h000 : (i == 1) ? 10'h3FF : seed[17:8];
      nv_write(adr, seed[7:0], i == 0);
      nv_read(adr);
    end
    // Strobe alone, arm with strobe together, and strobe after the arm lapses
    set_addr(10'h3FF);
    io_wr(eba_pkg::OFF_DATA, ~mem[1023]);
    io_wr(CTL, 8'h02);
    `CHK("strobe alone", 1'b0, wr_busy_o)
    io_wr(CTL, 8'h06);
    `CHK("arm with strobe", 1'b0, wr_busy_o)
    io_wr(CTL, 8'h04);
    repeat (4) @(negedge clk_i);
    io_wr(CTL, 8'h02);
    `CHK("lapsed arm", 1'b0, wr_busy_o)
    nv_read(10'h3FF);
    // Enable low freezes the halt counter, so only enabled cycles count towards the halt
    set_addr(10'h000);
    io_wr(CTL, 8'h01);
    ce_i = 1'b0;
    repeat (3) @(negedge clk_i);
    ce_i = 1'b1;
    stall_len(n);
    `CHK("frozen halt", 4, n)
    io_rd(eba_pkg::OFF_DATA, rd);
    `CHK("frozen read byte", mem[0], rd)
    final_report();
  end
endmodule : eba_access_tb
